// ===== bench/hmap_monitor.sv
// checker: timing relations on the shared host port pins
module hmap_monitor (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        host_port_select_n,
  input wire logic        host_address_latch,
  input wire logic        host_write_strobe_n,
  input wire logic        host_read_strobe_n,
  input wire logic        host_acknowledge_n,
  input wire logic        host_ad_host_oe,
  input wire logic        host_ad_dev_oe,
  input wire logic [15:0] host_addr_data_bus
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // decoded phases of the pins
  wire sel  = !host_port_select_n;
  wire wr   = sel && !host_write_strobe_n;
  wire rd   = sel && !host_read_strobe_n;
  wire busy = host_acknowledge_n;
  // first cycle of a write or read, and the cycle after a read
  sequence s_wr_start;
    wr && !$past(wr);
  endsequence
  sequence s_rd_start;
    rd && !$past(rd);
  endsequence
  sequence s_rd_end;
    !rd && $past(rd);
  endsequence
  a_wait_write: assert property (s_wr_start |-> !busy)
    else $error("write began while busy");
  a_wait_read: assert property (s_rd_start |-> !busy)
    else $error("read began while busy");
  a_write_busy: assert property (s_wr_start |=> busy)
    else $error("write start without busy");
  a_long_write_min: assert property (s_wr_start |=> busy [*2])
    else $error("write ready too early");
  a_write_ready_bound: assert property (s_wr_start |-> ##[1:6] !busy)
    else $error("write never ready");
  a_write_bus_drive: assert property (wr |-> host_ad_host_oe && !host_ad_dev_oe)
    else $error("bus not held by host in write");
  a_read_prev_drive: assert property (s_rd_start |=> busy && host_ad_dev_oe)
    else $error("read start not answered");
  a_read_data_setup: assert property ($fell(busy) && rd |-> $stable(host_addr_data_bus) && host_ad_dev_oe)
    else $error("read word not settled before ready");
  a_read_bus_release: assert property (s_rd_end |-> ##[1:2] !host_ad_dev_oe)
    else $error("bus still driven after read");
  a_latch_bus_quiet: assert property (sel && host_address_latch |-> !host_ad_dev_oe)
    else $error("device drove bus in latch phase");
  a_idle_ready: assert property (!sel && $past(!sel) |-> !busy)
    else $error("busy while port idle");
endmodule : hmap_monitor

// ===== bench/tb.sv
// testbench: host end and device end joined through the shared pins
module tb import hmap_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {hmap_cmd_e op; logic [15:0] d;} hmap_row_s;
  logic        ref_clk, rst, cmd_valid, cmd_ready, rsp_valid, core_ovl_we, short_read_only, access_done;
  hmap_cmd_e   cmd_op;
  logic [15:0] cmd_data, rsp_data, core_ovl_wdata, w;
  int          fail_count, num_checks, cyc, done_cnt;
  // latch rows carry an address, write rows data, read rows the expected word
  hmap_row_s rows [14] = '{'{HMAP_CMD_LATCH, 16'h0010}, '{HMAP_CMD_WRITE, 16'h1111},
    '{HMAP_CMD_WRITE, 16'h2222}, '{HMAP_CMD_WRITE, 16'h3333}, '{HMAP_CMD_LATCH, 16'h0010},
    '{HMAP_CMD_READ, 16'h1111}, '{HMAP_CMD_READ, 16'h2222}, '{HMAP_CMD_READ, 16'h3333},
    '{HMAP_CMD_LATCH, 16'h8004}, '{HMAP_CMD_WRITE, 16'hABCD}, '{HMAP_CMD_WRITE, 16'h00EF},
    '{HMAP_CMD_LATCH, 16'h8004}, '{HMAP_CMD_READ, 16'hABCD}, '{HMAP_CMD_READ, 16'h00EF}};
  hmap_if hp ();
  hmap_device u_hmap_device (.ref_clk(ref_clk), .rst(rst), .hp(hp), .core_ovl_we(core_ovl_we),
    .core_ovl_wdata(core_ovl_wdata), .short_read_only(short_read_only), .access_done(access_done));
  hmap_host u_hmap_host (.ref_clk(ref_clk), .rst(rst), .hp(hp), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  hmap_monitor u_hmap_monitor (.ref_clk(ref_clk), .rst(rst), .host_port_select_n(hp.host_port_select_n),
    .host_address_latch(hp.host_address_latch), .host_write_strobe_n(hp.host_write_strobe_n),
    .host_read_strobe_n(hp.host_read_strobe_n), .host_acknowledge_n(hp.host_acknowledge_n),
    .host_ad_host_oe(hp.host_ad_host_oe), .host_ad_dev_oe(hp.host_ad_dev_oe),
    .host_addr_data_bus(hp.host_addr_data_bus));
  // clock at 5 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // cycle ceiling and finished access count
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (access_done === 1'b1) done_cnt <= done_cnt + 1;
    if (cyc == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // hand one command to the host end once it is ready
  task send(input hmap_cmd_e op, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask : send
  task read_word(output logic [15:0] r);
    int n;
    n = 0;
    send(HMAP_CMD_READ, 16'h0000);
    while (rsp_valid !== 1'b1 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    r = rsp_data;
  endtask : read_word
  task core_ovl(input logic [15:0] d);
    @(negedge ref_clk);
    core_ovl_we = 1'b1;
    core_ovl_wdata = d;
    @(negedge ref_clk);
    core_ovl_we = 1'b0;
    @(negedge ref_clk);
  endtask : core_ovl
  task tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    {fail_count, num_checks, cyc, done_cnt} = '0;
    {cmd_valid, core_ovl_we, cmd_data, core_ovl_wdata} = '0;
    cmd_op = HMAP_CMD_LATCH;
    rst = 1'b1;
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    check("option after reset", {15'h0000, short_read_only}, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 14; i++) begin
      if (rows[i].op == HMAP_CMD_READ) begin
        read_word(w); // long reads only, with the option off
        check("read word", w, rows[i].d);
      end else begin
        send(rows[i].op, rows[i].d);
      end
    end
    $display("test table done");
    // the last read's done pulse is counted one edge after its response
    repeat (2) @(negedge ref_clk);
    check("finished accesses", done_cnt[15:0], 16'h000A);
    core_ovl(16'h4000);
    check("option by core", {15'h0000, short_read_only}, 16'h0001);
    send(HMAP_CMD_LATCH, OVL_ADDR);
    send(HMAP_CMD_WRITE, 16'h0000);
    send(HMAP_CMD_LATCH, 16'h0010);
    check("option by host", {15'h0000, short_read_only}, 16'h0000);
    $display("test overlay done");
    core_ovl(16'h4000);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    check("option after second reset", {15'h0000, short_read_only}, 16'h0000);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : tb

// ===== core/hmap_device.sv
// device end: decodes host strobes, accesses internal memories, answers with acknowledge
// How it works
// (RULE1) latch starts: select low, latch high
// (RULE2) latch ends: select high or latch low
// (RULE3) access starts: select low, strobe low
// (RULE4) write ends when select or strobe rises
// (RULE5) read ends: stop driving shared bus
// (RULE6) host waits acknowledge low before write
// (RULE7) host waits acknowledge low before read
// (RULE8) write start drives acknowledge high (busy)
// (RULE9) long write ack low after 1.5 periods
// (RULE10) short/long write by strobe end vs ack
// (RULE11) read start drives previously fetched word
// (RULE12) new word on bus before ack low
// (RULE13) program read done as two halves
// (RULE14) long read only while option off
// (RULE15) host should prefer short-read-only mode; this host always does long reads, waiting for acknowledge low
// (RULE16) overlay bit 14 enables option, reset off
// (RULE17) address advances after each data access
module hmap_device
  import hmap_pkg::*;
#(
  parameter int unsigned DM_DEPTH = 256,
  parameter int unsigned PM_DEPTH = 256
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  hmap_if.device                hp,
  input  wire logic             core_ovl_we,
  input  wire logic [BUS_W-1:0] core_ovl_wdata,
  output logic                  short_read_only,
  output logic                  access_done
);
  localparam int unsigned DM_AW = $clog2(DM_DEPTH);
  localparam int unsigned PM_AW = $clog2(PM_DEPTH);

  typedef enum logic [2:0] {
    HMAP_DS_IDLE  = 3'b000,
    HMAP_DS_LATCH = 3'b001,
    HMAP_DS_WR    = 3'b010,
    HMAP_DS_RD    = 3'b011,
    HMAP_DS_DONE  = 3'b100
  } hmap_dstate_e;

  hmap_dstate_e      st_q, st_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              pm_q, pm_d;        // access targets program memory
  logic              half_q, half_d;    // next program access is second half
  logic [BUS_W-1:0]  prev_q, prev_d;    // previously fetched word
  logic [BUS_W-1:0]  ovl_q, ovl_d;
  logic [2:0]        cnt_q, cnt_d;
  logic              ack_n_q, ack_n_d;
  logic              oe_q, oe_d;
  logic [BUS_W-1:0]  dout_q, dout_d;
  logic              done_q, done_d;
  logic [BUS_W-1:0]  dm_mem [DM_DEPTH];
  logic [23:0]       pm_mem [PM_DEPTH];
  logic [BUS_W-1:0]  wr_hold_q, wr_hold_d;  // last word seen on the bus during a write
  logic              dm_we, pm_we;
  logic [BUS_W-1:0]  fetch;

  logic latch_on, wr_on, rd_on;
  assign latch_on = !hp.host_port_select_n && hp.host_address_latch;   // [RULE1] [RULE2]
  assign wr_on    = !hp.host_port_select_n && !hp.host_write_strobe_n; // [RULE3] [RULE4]
  assign rd_on    = !hp.host_port_select_n && !hp.host_read_strobe_n;  // [RULE3] [RULE5]

  // word fetched for the next read; program words come as upper 16 then low 8
  always_comb begin
    if (pm_q) begin
      fetch = half_q ? {8'h00, pm_mem[addr_q[PM_AW-1:0]][7:0]} : pm_mem[addr_q[PM_AW-1:0]][23:8]; // [RULE13]
    end else begin
      fetch = dm_mem[addr_q[DM_AW-1:0]];
    end
  end

  // protocol next-state logic
  always_comb begin
    st_d    = st_q;
    addr_d  = addr_q;
    pm_d    = pm_q;
    half_d  = half_q;
    prev_d  = prev_q;
    ovl_d   = ovl_q;
    cnt_d   = cnt_q;
    ack_n_d = ack_n_q;
    oe_d    = oe_q;
    dout_d  = dout_q;
    done_d  = 1'b0;
    dm_we   = 1'b0;
    pm_we   = 1'b0;
    wr_hold_d = wr_on ? hp.host_addr_data_bus : wr_hold_q;          // [RULE4]
    if (core_ovl_we) begin
      ovl_d = core_ovl_wdata;                                         // [RULE16]
    end
    unique case (st_q)
      HMAP_DS_IDLE: begin
        if (latch_on) begin
          st_d = HMAP_DS_LATCH;                                       // [RULE1]
        end else if (wr_on) begin
          st_d    = HMAP_DS_WR;
          ack_n_d = 1'b1;                                             // [RULE8]
          cnt_d   = 3'(WR_ACK_CYC);
        end else if (rd_on) begin
          st_d    = HMAP_DS_RD;
          ack_n_d = 1'b1;
          oe_d    = 1'b1;
          dout_d  = prev_q;                                           // [RULE11]
          cnt_d   = 3'((pm_q && half_q) ? PM2_HOLD_CYC : PM1_HOLD_CYC); // [RULE13]
        end
      end
      HMAP_DS_LATCH: begin
        addr_d = hp.host_addr_data_bus[ADDR_W-1:0];
        pm_d   = hp.host_addr_data_bus[SPACE_BIT];
        half_d = 1'b0;
        if (!latch_on) begin
          st_d = HMAP_DS_IDLE;                                        // [RULE2]
        end
      end
      HMAP_DS_WR: begin
        if (cnt_q > 3'd1) begin
          cnt_d = cnt_q - 3'd1;
        end
        if (!wr_on || cnt_q <= 3'd1) begin
          // data captured at strobe end (short) or at ack time (long)
          st_d    = HMAP_DS_DONE;                                     // [RULE9] [RULE10]
          ack_n_d = 1'b0;
          done_d  = 1'b1;
          if ({2'b00, addr_q} == OVL_ADDR[ADDR_W+1:0] && !pm_q) begin
            ovl_d = wr_hold_q;                                        // [RULE16]
          end else if (pm_q) begin
            pm_we = 1'b1;
          end else begin
            dm_we = 1'b1;
          end
          if (!pm_q || half_q) begin
            addr_d = ADDR_W'(addr_q + 1'b1);                          // [RULE17]
          end
          half_d = pm_q && !half_q;
        end
      end
      HMAP_DS_RD: begin
        if (cnt_q > 3'd0) begin
          cnt_d = cnt_q - 3'd1;
        end
        if (!rd_on) begin
          oe_d    = 1'b0;                                             // [RULE5]
          ack_n_d = 1'b0;
          prev_d  = fetch;
          st_d    = HMAP_DS_IDLE;
          done_d  = 1'b1;
          if (!pm_q || half_q) begin
            addr_d = ADDR_W'(addr_q + 1'b1);                          // [RULE17]
          end
          half_d = pm_q && !half_q;
        end else if (cnt_q == 3'd0 && ack_n_q) begin
          if (!ovl_q[OVL_SRO_BIT]) begin
            dout_d  = fetch;                                          // [RULE12] [RULE14]
            prev_d  = fetch;
            cnt_d   = 3'(RD_SETUP_CYC);
            ack_n_d = 1'b0;
          end
        end
      end
      HMAP_DS_DONE: begin
        if (!wr_on && !rd_on) begin
          st_d = HMAP_DS_IDLE;
        end
      end
      default: st_d = HMAP_DS_IDLE;
    endcase
  end

  // new word must sit on the bus for the setup time before acknowledge falls
  logic ack_gate;
  assign ack_gate = (st_q == HMAP_DS_RD) && !ack_n_d && ack_n_q && oe_d && (dout_q != dout_d); // [RULE12]

  // state registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q    <= HMAP_DS_IDLE;
      addr_q  <= '0;
      pm_q    <= 1'b0;
      half_q  <= 1'b0;
      prev_q  <= '0;
      ovl_q   <= OVL_RESET;                                           // [RULE16]
      cnt_q   <= '0;
      ack_n_q <= 1'b0;
      oe_q    <= 1'b0;
      dout_q  <= '0;
      done_q  <= 1'b0;
      wr_hold_q <= '0;
    end else begin
      st_q    <= st_d;
      addr_q  <= addr_d;
      pm_q    <= pm_d;
      half_q  <= half_d;
      prev_q  <= prev_d;
      ovl_q   <= ovl_d;
      cnt_q   <= cnt_d;
      ack_n_q <= ack_gate ? 1'b1 : ack_n_d;
      oe_q    <= oe_d;
      dout_q  <= dout_d;
      done_q  <= done_d;
      wr_hold_q <= wr_hold_d;
    end
  end

  // memory arrays, no reset
  always_ff @(posedge ref_clk) begin
    if (dm_we) begin
      dm_mem[addr_q[DM_AW-1:0]] <= wr_hold_q;
    end
    if (pm_we && !half_q) begin
      pm_mem[addr_q[PM_AW-1:0]][23:8] <= wr_hold_q;
    end
    if (pm_we && half_q) begin
      pm_mem[addr_q[PM_AW-1:0]][7:0] <= wr_hold_q[7:0];
    end
  end

  assign hp.host_acknowledge_n = ack_n_q;
  assign hp.host_ad_dev_o      = dout_q;
  assign hp.host_ad_dev_oe     = oe_q;
  assign short_read_only       = ovl_q[OVL_SRO_BIT];
  assign access_done           = done_q;
endmodule : hmap_device

// ===== core/hmap_host.sv
// host end: turns user commands into strobe sequences on the shared pins
module hmap_host
  import hmap_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  hmap_if.host                  hp,
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  input  hmap_cmd_e             cmd_op,
  input  wire logic [BUS_W-1:0] cmd_data,
  output logic                  rsp_valid,
  output logic [BUS_W-1:0]      rsp_data
);
  typedef enum logic [2:0] {
    HMAP_HS_IDLE = 3'b000,
    HMAP_HS_WAIT = 3'b001,
    HMAP_HS_ACT  = 3'b010,
    HMAP_HS_HOLD = 3'b011,
    HMAP_HS_END  = 3'b100
  } hmap_hstate_e;

  hmap_hstate_e     st_q, st_d;
  hmap_cmd_e        op_q, op_d;
  logic [BUS_W-1:0] data_q, data_d;
  logic [BUS_W-1:0] rsp_q, rsp_d;
  logic             rv_q, rv_d;
  logic             sel_n_q, sel_n_d, al_q, al_d, wr_n_q, wr_n_d, rd_n_q, rd_n_d, oe_q, oe_d;

  // sequence: wait ack low, assert strobes, wait for device answer, release
  always_comb begin
    st_d    = st_q;
    op_d    = op_q;
    data_d  = data_q;
    rsp_d   = rsp_q;
    rv_d    = 1'b0;
    sel_n_d = sel_n_q;
    al_d    = al_q;
    wr_n_d  = wr_n_q;
    rd_n_d  = rd_n_q;
    oe_d    = oe_q;
    unique case (st_q)
      HMAP_HS_IDLE: begin
        if (cmd_valid) begin
          op_d   = cmd_op;
          data_d = cmd_data;
          st_d   = HMAP_HS_WAIT;
        end
      end
      HMAP_HS_WAIT: begin
        if (!hp.host_acknowledge_n) begin                           // [RULE6] [RULE7]
          sel_n_d = 1'b0;
          st_d    = HMAP_HS_ACT;
          if (op_q == HMAP_CMD_LATCH) begin
            al_d = 1'b1;                                            // [RULE1]
            oe_d = 1'b1;
          end else if (op_q == HMAP_CMD_WRITE) begin
            wr_n_d = 1'b0;                                          // [RULE3]
            oe_d   = 1'b1;
          end else begin
            rd_n_d = 1'b0;                                          // [RULE3]
          end
        end
      end
      HMAP_HS_ACT: begin
        st_d = HMAP_HS_HOLD;                                        // let device see start
      end
      HMAP_HS_HOLD: begin
        if (op_q == HMAP_CMD_LATCH || !hp.host_acknowledge_n) begin
          // long cycles: release after ack low; read data taken then
          rsp_d   = hp.host_addr_data_bus;                          // [RULE10] [RULE12]
          al_d    = 1'b0;                                           // [RULE2]
          wr_n_d  = 1'b1;                                           // [RULE4]
          rd_n_d  = 1'b1;                                           // [RULE5]
          sel_n_d = 1'b1;
          st_d    = HMAP_HS_END;
        end
      end
      HMAP_HS_END: begin
        oe_d = 1'b0;
        rv_d = (op_q == HMAP_CMD_READ);
        st_d = HMAP_HS_IDLE;
      end
      default: begin
        st_d = HMAP_HS_IDLE;
      end
    endcase
  end

  // registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q    <= HMAP_HS_IDLE;
      op_q    <= HMAP_CMD_LATCH;
      data_q  <= '0;
      rsp_q   <= '0;
      rv_q    <= 1'b0;
      sel_n_q <= 1'b1;
      al_q    <= 1'b0;
      wr_n_q  <= 1'b1;
      rd_n_q  <= 1'b1;
      oe_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      op_q    <= op_d;
      data_q  <= data_d;
      rsp_q   <= rsp_d;
      rv_q    <= rv_d;
      sel_n_q <= sel_n_d;
      al_q    <= al_d;
      wr_n_q  <= wr_n_d;
      rd_n_q  <= rd_n_d;
      oe_q    <= oe_d;
    end
  end

  assign cmd_ready              = (st_q == HMAP_HS_IDLE);
  assign rsp_valid              = rv_q;
  assign rsp_data               = rsp_q;
  assign hp.host_port_select_n  = sel_n_q;
  assign hp.host_address_latch  = al_q;
  assign hp.host_write_strobe_n = wr_n_q;
  assign hp.host_read_strobe_n  = rd_n_q;
  assign hp.host_ad_host_o      = data_q;
  assign hp.host_ad_host_oe     = oe_q;
endmodule : hmap_host

// ===== core/hmap_if.sv
// interface: shared pins between host and device ends
interface hmap_if;
  logic       host_port_select_n;
  logic       host_address_latch;
  logic       host_write_strobe_n;
  logic       host_read_strobe_n;
  logic       host_acknowledge_n;
  logic [15:0] host_ad_host_o;
  logic       host_ad_host_oe;
  logic [15:0] host_ad_dev_o;
  logic       host_ad_dev_oe;
  logic [15:0] host_addr_data_bus;
  // resolved bus level, pulled to zero when nobody drives
  assign host_addr_data_bus = host_ad_dev_oe ? host_ad_dev_o : (host_ad_host_oe ? host_ad_host_o : 16'h0000);
  modport device (
    input  host_port_select_n, host_address_latch, host_write_strobe_n, host_read_strobe_n, host_addr_data_bus,
    output host_acknowledge_n, host_ad_dev_o, host_ad_dev_oe
  );
  modport host (
    output host_port_select_n, host_address_latch, host_write_strobe_n, host_read_strobe_n,
    output host_ad_host_o, host_ad_host_oe,
    input  host_acknowledge_n, host_addr_data_bus
  );
endinterface : hmap_if

// ===== core/hmap_pkg.sv
// package: constants and types shared by both ends of the host memory access port
package hmap_pkg;
  localparam int unsigned CLK_PERIOD_PS    = 5000;  // ref_clk period, 200 MHz
  localparam int unsigned WR_ACK_MIN_PS    = 7500;  // long write: 1.5 clock periods
  localparam int unsigned RD_SETUP_MIN_PS  = 2500;  // long read: data before ack low, 0.5 period
  localparam int unsigned WR_ACK_CYC       = (WR_ACK_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RD_SETUP_CYC     = (RD_SETUP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PM1_HOLD_CYC     = 2;     // previous data hold, data / first half
  localparam int unsigned PM2_HOLD_CYC     = 1;     // previous data hold, second half
  localparam int unsigned BUS_W            = 16;
  localparam int unsigned ADDR_W           = 14;
  localparam int unsigned OVL_SRO_BIT      = 14;    // short-read-only bit in overlay control
  localparam logic [BUS_W-1:0] OVL_ADDR    = 16'h3FE7;
  localparam logic [BUS_W-1:0] OVL_RESET   = 16'h0000;
  localparam int unsigned SPACE_BIT        = 15;    // address word bit: 1 = program memory
  typedef logic [BUS_W-1:0] hmap_word_t;
  // host command encodings
  typedef enum logic [1:0] {
    HMAP_CMD_LATCH = 2'b00,
    HMAP_CMD_WRITE = 2'b01,
    HMAP_CMD_READ  = 2'b10
  } hmap_cmd_e;
endpackage : hmap_pkg
